//--- bench/i2c_rd_seq_monitor.sv
// port checker for the read sequencer
// assumes one clock and bus edges two clocks apart
`timescale 1ns/1ps
module i2c_rd_seq_monitor #(parameter AW = 11) (
   input wire          clk_i,
   input wire          rstn_i,
   input wire          scl_i,
   input wire          sda_i,
   input wire          sda_o,
   input wire          sda_oe_o,
   input wire [AW-1:0] mem_addr_o,
   input wire          busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_start; scl_i && $past(scl_i) && $fell(sda_i); endsequence
   sequence s_stop; scl_i && $past(scl_i) && $rose(sda_i); endsequence
   property p_idle; !busy_o |-> !sda_oe_o; endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_stop; s_stop |-> ##[1:2] !busy_o; endproperty
   a_stop: assert property (p_stop) else $error("stop missed");
   property p_rel; s_stop |=> !sda_oe_o; endproperty
   a_rel: assert property (p_rel) else $error("stop drive");
   property p_start; s_start |-> ##[1:2] busy_o; endproperty
   a_start: assert property (p_start) else $error("start missed");
   property p_od; !sda_o; endproperty
   a_od: assert property (p_od) else $error("sda high");
   property p_edge; $changed(sda_oe_o) |-> !$past(scl_i) && $past(scl_i, 2); endproperty
   a_edge: assert property (p_edge) else $error("late edge");
   property p_hold; $rose(sda_oe_o) |-> sda_oe_o [*4]; endproperty
   a_hold: assert property (p_hold) else $error("short bit");
   // a word load of zero right after the top address would trip this
   property p_wrap; $past(mem_addr_o) == 11'h7ff && ~|mem_addr_o[7:0] |-> ~|mem_addr_o; endproperty
   a_wrap: assert property (p_wrap) else $error("bad wrap");
   property p_quiet; !busy_o && !(scl_i && $past(scl_i) && $fell(sda_i)) |=> !busy_o; endproperty
   a_quiet: assert property (p_quiet) else $error("woke without start");
endmodule
bind i2c_rd_seq i2c_rd_seq_monitor #(.AW(AW)) u_mon (.*);

//--- bench/i2c_rd_seq_tb.sv
// bench: master tasks run selective, current and aborted reads
// assumes the pattern of the memory stand-in
`timescale 1ns/1ps
module i2c_memory_read_sequencer_tb_top;
   reg clk_i = 0, rstn_i = 0, scl = 1, sdm = 1, a;
   reg [10:0] k;
   reg [7:0] v;
   wire oe, busy;
   wire [10:0] ma;
   wire [7:0] md;
   wire sda = sdm & ~oe;
   integer fail_count = 0, n_compared = 0, i;
   i2c_rd_seq u_i2c_rd_seq (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(oe), .mem_addr_o(ma), .mem_data_i(md), .busy_o(busy));
   mem_model u_mem_model (.addr_i(ma), .data_o(md));
   initial forever #2.5 clk_i = ~clk_i;
   task step(input integer n); repeat (n) @(posedge clk_i); #1; endtask
   task bitx(input b); sdm = b; step(3); scl = 1; step(2); a = sda; step(2); scl = 0; step(1); endtask
   task start; sdm = 1; step(3); scl = 1; step(3); sdm = 0; step(3); scl = 0; step(2); endtask
   task stop; sdm = 0; step(3); scl = 1; step(3); sdm = 1; step(3); endtask
   task chk(input [10:0] g, e); n_compared = n_compared + 1;
      if (g !== e) begin fail_count = fail_count + 1; $display("ERROR %0t got %h", $time, g); end
   endtask
   task wbyte(input [7:0] b); for (i = 7; i >= 0; i = i - 1) bitx(b[i]); bitx(1); k = {10'h000, !a}; endtask
   task rbyte(input [10:0] d); for (i = 7; i >= 0; i = i - 1) begin bitx(1); v[i] = a; end
      chk({3'h0, v}, {3'h0, d[7:0] ^ {d[10:8], 5'h00}});
   endtask
   task t_sel;
      start; wbyte(8'h5e); chk(k, 11'h001);
      wbyte(8'hfe); chk(k, 11'h001);
      start; wbyte(8'h5f); chk(k, 11'h001);
      rbyte(11'h7fe); bitx(0); rbyte(11'h7ff); bitx(0);
      rbyte(11'h000); bitx(1);
      stop; chk({10'h000, busy}, 11'h000);
   endtask
   task t_cur;
      start; wbyte(8'h55); chk(k, 11'h001);
      rbyte(11'h201); bitx(1);
      start; wbyte(8'h51); chk(k, 11'h001);
      rbyte(11'h002); stop; chk({10'h000, busy}, 11'h000);
   endtask
   task t_abt;
      start; wbyte(8'h51); rbyte(11'h003); start; wbyte(8'h51); chk(k, 11'h001);
      rbyte(11'h004); bitx(1); stop;
      start; wbyte(8'h91); chk(k, 11'h000);
      start; bitx(0); bitx(1); stop; chk({10'h000, busy}, 11'h000);
   endtask
   task complete_run; $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin #100000; fail_count = fail_count + 1; complete_run; end
   initial begin step(8); rstn_i = 1; step(2); t_sel; t_cur; t_abt; complete_run; end
endmodule

//--- bench/mem_model.sv
// memory stand-in for the sequencer read port
// assumes a combinational read
`timescale 1ns/1ps
module mem_model (input wire [10:0] addr_i, output wire [7:0] data_o);
   // page bits mixed in so a wrong page shows in the data
   assign data_o = addr_i[7:0] ^ {addr_i[10:8], 5'h00};
endmodule

//--- verilog/i2c_rd_seq.v
// i2c memory slave: address phase, word-address load and sequential reads
// assumes scl_i/sda_i are synchronous to clk_i; memory read is combinational via mem_addr_o/mem_data_i
`timescale 1ns/1ps
`include "i2c_rd_seq_defs.vh"
module i2c_rd_seq #(
   parameter [3:0] DEV_TYPE = 4'h5, // arbitrary device type code
   parameter       AW       = 11
) (
   input  wire          clk_i,
   input  wire          rstn_i,
   input  wire          scl_i,
   input  wire          sda_i,
   output wire          sda_o,
   output wire          sda_oe_o,
   output wire [AW-1:0] mem_addr_o,
   input  wire [7:0]    mem_data_i,
   output wire          busy_o
);
   localparam S_IDLE = 3'h0;
   localparam S_DEVA = 3'h1;
   localparam S_AACK = 3'h2;
   localparam S_WORD = 3'h3;
   localparam S_WACK = 3'h4;
   localparam S_RDAT = 3'h5;
   localparam S_MACK = 3'h6;
   localparam S_WAIT = 3'h7;

   reg [2:0]    state_reg;
   reg [2:0]    state_next;
   reg [2:0]    bit_reg;
   reg [2:0]    bit_next;
   reg [3:0]    cnt_reg;
   reg [3:0]    cnt_next;
   reg [7:0]    shift_reg;
   reg [7:0]    shift_next;
   reg [AW-1:0] addr_reg;
   reg [AW-1:0] addr_next;
   reg          rd_reg;
   reg          rd_next;
   reg          drive_reg;
   reg          drive_next;
   reg          scl_q_reg;
   reg          sda_q_reg;

   // edges are seen in the same clock the pin changes, against the delayed copies of the pins
   wire scl_rise = scl_i & ~scl_q_reg;
   wire scl_fall = ~scl_i & scl_q_reg;
   wire start_c  = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
   wire stop_c   = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
   // a full byte is eight sampled rises; counting rises keeps a zero byte legal
   wire byte_end = scl_fall & (cnt_reg == `CNT_BYTE);
   wire addr_hit = shift_reg[`DEV_TYPE_HI:`DEV_TYPE_LO] == DEV_TYPE;

   assign sda_o      = 1'b0;
   assign sda_oe_o   = drive_reg;
   assign mem_addr_o = addr_reg;
   assign busy_o     = state_reg != S_IDLE;

   // open drain: pull low for a zero bit, release for a one; idx 0 is the msb
   function pull_for_bit;
      input [7:0] data;
      input [2:0] idx;
      begin
         pull_for_bit = ~data[`BIT_LAST - idx];
      end
   endfunction

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_i;
         sda_q_reg <= sda_i;
      end
   end

   always @* begin
      state_next = state_reg;
      bit_next   = bit_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      addr_next  = addr_reg;
      rd_next    = rd_reg;
      drive_next = drive_reg;
      if (stop_c) begin
         // a stop anywhere drops the transfer and frees the line
         state_next = S_IDLE;
         drive_next = 1'b0;
      end else if (start_c) begin
         // a restart also abandons a pending write, so nothing is stored
         state_next = S_DEVA;
         bit_next   = `BIT_FIRST;
         cnt_next   = `CNT_ZERO;
         drive_next = 1'b0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               drive_next = 1'b0;
            end
            S_DEVA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[`SHIFT_TOP:`SHIFT_LO], sda_i};
                  cnt_next   = cnt_reg + `CNT_STEP;
               end
               if (byte_end) begin
                  if (addr_hit) begin
                     rd_next    = shift_reg[`DIR_BIT];
                     addr_next  = {shift_reg[`PAGE_HI:`PAGE_LO], addr_reg[`LOW_HI:`LOW_LO]};
                     drive_next = 1'b1;
                     state_next = S_AACK;
                  end else begin
                     // another device type: stay off the bus until start or stop
                     state_next = S_WAIT;
                  end
               end
            end
            S_AACK: begin
               if (scl_fall) begin
                  bit_next = `BIT_FIRST;
                  cnt_next = `CNT_ZERO;
                  if (rd_reg) begin
                     drive_next = pull_for_bit(mem_data_i, `BIT_FIRST);
                     state_next = S_RDAT;
                  end else begin
                     drive_next = 1'b0;
                     state_next = S_WORD;
                  end
               end
            end
            S_WORD: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[`SHIFT_TOP:`SHIFT_LO], sda_i};
                  cnt_next   = cnt_reg + `CNT_STEP;
               end
               if (byte_end) begin
                  addr_next[`LOW_HI:`LOW_LO] = shift_reg;
                  drive_next                 = 1'b1;
                  state_next                 = S_WACK;
               end
            end
            S_WACK: begin
               // no write data path here: after this ack only a restart or stop matters
               if (scl_fall) begin
                  drive_next = 1'b0;
                  state_next = S_WAIT;
               end
            end
            S_RDAT: begin
               if (scl_fall) begin
                  if (bit_reg == `BIT_LAST) begin
                     drive_next = 1'b0;
                     addr_next  = addr_reg + `ADDR_ONE;
                     state_next = S_MACK;
                  end else begin
                     bit_next   = bit_reg + `BIT_STEP;
                     drive_next = pull_for_bit(mem_data_i, bit_reg + `BIT_STEP);
                  end
               end
            end
            S_MACK: begin
               // the line stays released so the master may ack, nack, start or stop
               if (scl_rise) begin
                  rd_next = ~sda_i;
               end
               if (scl_fall) begin
                  bit_next = `BIT_FIRST;
                  if (rd_reg) begin
                     drive_next = pull_for_bit(mem_data_i, `BIT_FIRST);
                     state_next = S_RDAT;
                  end else begin
                     // a no-acknowledge ends the read; further clocks are ignored
                     state_next = S_WAIT;
                  end
               end
            end
            S_WAIT: begin
               drive_next = 1'b0;
            end
            default: begin
               state_next = S_IDLE;
               drive_next = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= S_IDLE;
         bit_reg   <= `BIT_FIRST;
         cnt_reg   <= `CNT_ZERO;
         shift_reg <= `BYTE_ZERO;
         addr_reg  <= `ADDR_RST;
         rd_reg    <= 1'b0;
         drive_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_reg   <= bit_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         addr_reg  <= addr_next;
         rd_reg    <= rd_next;
         drive_reg <= drive_next;
      end
   end
endmodule

//--- verilog/i2c_rd_seq_defs.vh
// constants for the two-wire memory read sequencer
// assumes scl and sda are sampled on clk_i and are glitch free
`ifndef I2C_RD_SEQ_DEFS_VH
`define I2C_RD_SEQ_DEFS_VH
`define DEV_TYPE_HI     7
`define DEV_TYPE_LO     4
`define PAGE_HI         3
`define PAGE_LO         1
`define DIR_BIT         0
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
`define ADDR_ONE        11'h001
`define ADDR_RST        11'h000
`define CNT_ZERO        4'h0
`define CNT_STEP        4'h1
`define CNT_BYTE        4'h8
`define BIT_STEP        3'h1
`define BYTE_ZERO       8'h00
`define LOW_HI          7
`define LOW_LO          0
`define SHIFT_TOP       6
`define SHIFT_LO        0
`endif
